// ---- hdl/piopu_cfg.svh ----
`ifndef PIOPU_CFG_SVH
`define PIOPU_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PIOPU_IDX_MODE_LO 8'h70
`define PIOPU_IDX_DIR_LO 8'h72
`define PIOPU_IDX_LEVEL_LO 8'h74
`define PIOPU_IDX_MODE_HI 8'h76
`define PIOPU_IDX_DIR_HI 8'h78
`define PIOPU_IDX_LEVEL_HI 8'h7A

// ----------------------------------------------------------------
// Widths and field layout
// ----------------------------------------------------------------
`define PIOPU_PINS 32
`define PIOPU_HALF 16
`define PIOPU_ADDR_W 12
`define PIOPU_IDX_LSB 2
`define PIOPU_IDX_MSB 9
`define PIOPU_STRAP_PIN_A 26
`define PIOPU_STRAP_PIN_B 29

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIOPU_RST_MODE_LO 16'h0000
`define PIOPU_RST_MODE_HI 16'h0000
`define PIOPU_RST_DIR_LO 16'hFC0F
`define PIOPU_RST_DIR_HI 16'hFFFF
`define PIOPU_RST_LEVEL 16'h0000
`define PIOPU_RST_WORD 32'h0000_0000
`define PIOPU_RST_HALF 16'h0000

// Pins whose pulled input uses a pull-down; all others pull up
`define PIOPU_PULLDOWN_MASK 32'h0000_0442

`endif

// ---- hdl/piopu_pkg.sv ----
`include "piopu_cfg.svh"

package piopu_pkg;

    // ----------------------------------------------------------------
    // Pin function chosen by the mode and direction bits
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PIOPU_FN_NORMAL,
        PIOPU_FN_IN_PULL,
        PIOPU_FN_OUT,
        PIOPU_FN_IN_FLOAT
    } piopu_fn_e;

    typedef logic [`PIOPU_HALF-1:0] piopu_half_t;
    typedef logic [`PIOPU_PINS-1:0] piopu_word_t;
    typedef logic [`PIOPU_IDX_MSB-`PIOPU_IDX_LSB:0] piopu_idx_t;

    function automatic piopu_fn_e piopu_decode(input logic modeBit, input logic dirBit);
        piopu_fn_e fn;
        fn = PIOPU_FN_NORMAL;
        case ({modeBit, dirBit})
            2'b00: fn = PIOPU_FN_NORMAL;
            2'b01: fn = PIOPU_FN_IN_PULL;
            2'b10: fn = PIOPU_FN_OUT;
            2'b11: fn = PIOPU_FN_IN_FLOAT;
            default: fn = PIOPU_FN_NORMAL;
        endcase
        return fn;
    endfunction : piopu_decode

endpackage : piopu_pkg

// ---- hdl/piopu_reg_if.sv ----
`timescale 1ns/1ps

// Register access strobes between the bus slave and the register file
interface piopu_reg_if;
    import piopu_pkg::*;

    logic wrStb;
    piopu_idx_t idx;
    piopu_half_t wrData;
    piopu_half_t rdData;
    logic hit;

    modport bus
    (
        output wrStb,
        output idx,
        output wrData,
        input rdData,
        input hit
    );

    modport regs
    (
        input wrStb,
        input idx,
        input wrData,
        output rdData,
        output hit
    );
endinterface : piopu_reg_if

// ---- hdl/piopu_sync.sv ----
`timescale 1ns/1ps

// Two-stage synchroniser; only the second stage leaves the module
module piopu_sync #(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule : piopu_sync

// ---- hdl/piopu_apb_slave.sv ----
`timescale 1ns/1ps
`include "piopu_cfg.svh"

// APB slave: one access cycle, no wait states
module piopu_apb_slave
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIOPU_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Register file
    piopu_reg_if.bus regPort
);
    import piopu_pkg::*;

    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic setup;
    logic aligned;

    assign setup = psel & ~penable;
    assign aligned = (paddr[`PIOPU_IDX_LSB-1:0] == 2'b00);
    assign regPort.idx = paddr[`PIOPU_IDX_MSB:`PIOPU_IDX_LSB];
    assign regPort.wrData = pwdata[`PIOPU_HALF-1:0];
    // Write lands on the completing edge only
    assign regPort.wrStb = psel & penable & pready_q & pwrite & ~pslverr_q;

    // ----------------------------------------------------------------
    // Answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `PIOPU_RST_WORD;
        end
        else
        begin
            pready_q <= setup;
            if (setup)
            begin
                pslverr_q <= ~(regPort.hit & aligned);
                // Upper half reads as zero
                prdata_q <= (regPort.hit & aligned & ~pwrite) ?
                    {`PIOPU_RST_HALF, regPort.rdData} : `PIOPU_RST_WORD;
            end
            else if (pready_q)
            begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule : piopu_apb_slave

// ---- hdl/piopu_top.sv ----
//
// Contract
// R01: 32 pins; I/O setting blocks normal function
// R02: Mode/direction pair selects one of four functions
// R03: Reset leaves pins normal or pulled input
// R04: Upper mode register maps pins 31..16
// R05: Lower mode pins 15..0; modes reset zero
// R06: Direction resets FFFF upper, FC0F lower
// R07: Direction one input, zero output or normal
// R08: Direction bits map like mode bits
// R09: Output pin drives its data bit
// R10: Input data bit reads pin level uninverted
// R11: Pins 4 to 9 boot in normal operation
// R12: Pins 1, 6, 10 pull down; others pull up
// R13: Low strap at reset makes 26, 29 normal
// R14: Pins 4,5,7,8,9 pull up; 6 down
// R15: Open drain: software toggles direction, fixed data
// R16: Data registers map pins 31..16 and 15..0
// R17: Pin inputs synchronised twice before reading
// R18: Data writes stored even while input
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "piopu_cfg.svh"

module piopu_top
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIOPU_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap sampled after reset release
    input wire logic addrEnableStrapN,
    // Normal peripheral functions
    input wire logic [`PIOPU_PINS-1:0] normOut,
    input wire logic [`PIOPU_PINS-1:0] normOe,
    output logic [`PIOPU_PINS-1:0] normIn,
    // Pins
    input wire logic [`PIOPU_PINS-1:0] pinIn,
    output logic [`PIOPU_PINS-1:0] pinOut,
    output logic [`PIOPU_PINS-1:0] pinOeN,
    output logic [`PIOPU_PINS-1:0] pullUpEn,
    output logic [`PIOPU_PINS-1:0] pullDownEn
);
    import piopu_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    piopu_half_t modeLo_q;
    piopu_half_t modeHi_q;
    piopu_half_t dirLo_q;
    piopu_half_t dirHi_q;
    piopu_half_t levelLo_q;
    piopu_half_t levelHi_q;
    logic strapDone_q;

    piopu_word_t mode;
    piopu_word_t dir;
    piopu_word_t level;
    piopu_word_t pinSync;
    piopu_word_t readBack;
    piopu_word_t pullDownMask;

    logic [`PIOPU_PINS-1:0] pinOut_q;
    logic [`PIOPU_PINS-1:0] pinOeN_q;
    logic [`PIOPU_PINS-1:0] pullUp_q;
    logic [`PIOPU_PINS-1:0] pullDown_q;
    logic [`PIOPU_PINS-1:0] normIn_q;

    piopu_reg_if regBus ();

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    piopu_apb_slave u_apb
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .regPort(regBus.bus)
    );

    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    // Pin levels may change at any time; two stages keep metastability
    // out of the read path and the peripheral inputs
    piopu_sync #(
        .WIDTH(`PIOPU_PINS)
    ) u_sync
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    ); // [R17]

    // Upper register holds pins 31..16, MSB is pin 31
    assign mode = {modeHi_q, modeLo_q}; // [R04] [R05]
    assign dir = {dirHi_q, dirLo_q}; // [R08]
    assign level = {levelHi_q, levelLo_q}; // [R16]
    assign pullDownMask = `PIOPU_PULLDOWN_MASK;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    always_comb
    begin
        regBus.hit = 1'b1;
        regBus.rdData = `PIOPU_RST_HALF;
        case (regBus.idx)
            `PIOPU_IDX_MODE_LO: regBus.rdData = modeLo_q;
            `PIOPU_IDX_DIR_LO: regBus.rdData = dirLo_q;
            `PIOPU_IDX_LEVEL_LO: regBus.rdData = readBack[`PIOPU_HALF-1:0];
            `PIOPU_IDX_MODE_HI: regBus.rdData = modeHi_q;
            `PIOPU_IDX_DIR_HI: regBus.rdData = dirHi_q;
            `PIOPU_IDX_LEVEL_HI: regBus.rdData = readBack[`PIOPU_PINS-1:`PIOPU_HALF];
            default: regBus.hit = 1'b0;
        endcase
    end

    // Driven outputs read back the stored bit, all others the pin
    always_comb
    begin
        for (int i = 0; i < `PIOPU_PINS; i++)
        begin
            readBack[i] = (piopu_decode(mode[i], dir[i]) == PIOPU_FN_OUT) ?
                level[i] : pinSync[i]; // [R10]
        end
    end

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            modeLo_q <= `PIOPU_RST_MODE_LO; // [R05] [R03]
            modeHi_q <= `PIOPU_RST_MODE_HI; // [R05]
        end
        else if (regBus.wrStb)
        begin
            if (regBus.idx == `PIOPU_IDX_MODE_LO)
            begin
                modeLo_q <= regBus.wrData;
            end
            if (regBus.idx == `PIOPU_IDX_MODE_HI)
            begin
                modeHi_q <= regBus.wrData; // [R04]
            end
        end
    end

    // ----------------------------------------------------------------
    // Direction registers and strap
    // ----------------------------------------------------------------
    // FC0F leaves pins 4..9 normal and the rest as pulled inputs
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            dirLo_q <= `PIOPU_RST_DIR_LO; // [R06] [R11] [R03]
            dirHi_q <= `PIOPU_RST_DIR_HI; // [R06]
        end
        else
        begin
            if (regBus.wrStb && regBus.idx == `PIOPU_IDX_DIR_LO)
            begin
                dirLo_q <= regBus.wrData; // [R07]
            end
            if (regBus.wrStb && regBus.idx == `PIOPU_IDX_DIR_HI)
            begin
                dirHi_q <= regBus.wrData; // [R07]
            end
            // Strap is caught on the first edge after release; a bus
            // write cannot complete that early, so nothing is lost
            if (!strapDone_q && !addrEnableStrapN)
            begin
                dirHi_q[`PIOPU_STRAP_PIN_A-`PIOPU_HALF] <= 1'b0; // [R13]
                dirHi_q[`PIOPU_STRAP_PIN_B-`PIOPU_HALF] <= 1'b0; // [R13]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            strapDone_q <= 1'b0;
        end
        else
        begin
            strapDone_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    // Stored regardless of direction, so a later switch to output
    // drives what software last wrote
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            levelLo_q <= `PIOPU_RST_LEVEL;
            levelHi_q <= `PIOPU_RST_LEVEL;
        end
        else if (regBus.wrStb)
        begin
            if (regBus.idx == `PIOPU_IDX_LEVEL_LO)
            begin
                levelLo_q <= regBus.wrData; // [R18] [R16]
            end
            if (regBus.idx == `PIOPU_IDX_LEVEL_HI)
            begin
                levelHi_q <= regBus.wrData; // [R18] [R16]
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Open drain needs no logic of its own: software holds the data
    // bit low and flips direction, so the pin drives low or floats
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pinOut_q <= '0;
            pinOeN_q <= '1;
            pullUp_q <= '0;
            pullDown_q <= '0;
        end
        else
        begin
            for (int i = 0; i < `PIOPU_PINS; i++)
            begin
                pullUp_q[i] <= 1'b0;
                pullDown_q[i] <= 1'b0;
                case (piopu_decode(mode[i], dir[i])) // [R02]
                    PIOPU_FN_NORMAL:
                    begin
                        pinOut_q[i] <= normOut[i];
                        pinOeN_q[i] <= ~normOe[i];
                    end
                    PIOPU_FN_IN_PULL:
                    begin
                        // Normal function blocked from the pin
                        pinOut_q[i] <= 1'b0; // [R01]
                        pinOeN_q[i] <= 1'b1; // [R01]
                        pullDown_q[i] <= pullDownMask[i]; // [R12] [R14]
                        pullUp_q[i] <= ~pullDownMask[i]; // [R12] [R14]
                    end
                    PIOPU_FN_OUT:
                    begin
                        pinOut_q[i] <= level[i]; // [R09]
                        pinOeN_q[i] <= 1'b0; // [R09]
                    end
                    PIOPU_FN_IN_FLOAT:
                    begin
                        pinOut_q[i] <= 1'b0; // [R01]
                        pinOeN_q[i] <= 1'b1; // [R07] [R15]
                    end
                    default:
                    begin
                        pinOut_q[i] <= 1'b0;
                        pinOeN_q[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Peripheral input path
    // ----------------------------------------------------------------
    // Peripherals only see the pin while it is in normal operation;
    // otherwise they see a quiet low
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            normIn_q <= '0;
        end
        else
        begin
            for (int i = 0; i < `PIOPU_PINS; i++)
            begin
                normIn_q[i] <= (piopu_decode(mode[i], dir[i]) == PIOPU_FN_NORMAL) ?
                    pinSync[i] : 1'b0; // [R01]
            end
        end
    end

    assign pinOut = pinOut_q;
    assign pinOeN = pinOeN_q;
    assign pullUpEn = pullUp_q;
    assign pullDownEn = pullDown_q;
    assign normIn = normIn_q;
endmodule : piopu_top

// ---- verification/piopu_top_assertions.sv ----
`timescale 1ns/1ps
`include "piopu_cfg.svh"

module piopu_top_assertions
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIOPU_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Strap and normal functions
    input wire logic addrEnableStrapN,
    input wire logic [`PIOPU_PINS-1:0] normOut,
    input wire logic [`PIOPU_PINS-1:0] normOe,
    input wire logic [`PIOPU_PINS-1:0] normIn,
    // Pins
    input wire logic [`PIOPU_PINS-1:0] pinIn,
    input wire logic [`PIOPU_PINS-1:0] pinOut,
    input wire logic [`PIOPU_PINS-1:0] pinOeN,
    input wire logic [`PIOPU_PINS-1:0] pullUpEn,
    input wire logic [`PIOPU_PINS-1:0] pullDownEn
);
    // ----------------------------------------------------------------
    // Boot tracking
    // ----------------------------------------------------------------
    logic [1:0] upCnt_q;
    logic strapN_q;
    logic written_q;
    logic booted;

    always_ff @(posedge clk_sys or posedge reset)
        if (reset)
            upCnt_q <= 2'h0;
        else if (upCnt_q != 2'h2)
            upCnt_q <= upCnt_q + 2'h1;

    // Strap is only meaningful at the first edge after release
    always_ff @(posedge clk_sys or posedge reset)
        if (reset)
            strapN_q <= 1'b1;
        else if (upCnt_q == 2'h0)
            strapN_q <= addrEnableStrapN;

    // Any write may alter pin setup, so boot checks stop there
    always_ff @(posedge clk_sys or posedge reset)
        if (reset)
            written_q <= 1'b0;
        else if (psel && penable && pready && pwrite)
            written_q <= 1'b1;

    // Pins show the post-strap setup only from the second edge on
    always_comb booted = (upCnt_q == 2'h2) && !written_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    error_read_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    read_upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    pull_only_input_a: assert property (((pullUpEn & pullDownEn) == 32'h0)
        && (((pullUpEn | pullDownEn) & ~pinOeN) == 32'h0))
        else $error("pull while driving or both pulls");
    pull_kind_a: assert property (((pullDownEn & ~`PIOPU_PULLDOWN_MASK) == 32'h0)
        && ((pullUpEn & `PIOPU_PULLDOWN_MASK) == 32'h0))
        else $error("wrong pull kind");
    boot_pulls_a: assert property (booted |-> pullDownEn == 32'h0000_0402
        && (pullUpEn & 32'hDBFF_FFFF) == 32'hDBFF_F80D)
        else $error("boot pull pattern wrong");
    boot_normal_a: assert property (booted |-> ((pinOeN ^ ~$past(normOe)) & 32'h3F0) == 32'h0
        && ((pinOut ^ $past(normOut)) & 32'h3F0) == 32'h0)
        else $error("boot pins not in normal operation");
    strap_pins_a: assert property (booted |-> pullUpEn[26] == strapN_q
        && pullUpEn[29] == strapN_q)
        else $error("strap pins wrong");
    normal_gate_a: assert property ((normIn & (pullUpEn | pullDownEn)) == 32'h0)
        else $error("normal input seen on I/O pin");

    write_c: cover property (psel && penable && pready && pwrite && !pslverr);
    refused_c: cover property (pready && pslverr);
    strap_low_c: cover property (booted && !strapN_q);
endmodule : piopu_top_assertions

bind piopu_top piopu_top_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .addrEnableStrapN(addrEnableStrapN),
    .normOut(normOut), .normOe(normOe), .normIn(normIn), .pinIn(pinIn), .pinOut(pinOut),
    .pinOeN(pinOeN), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn));

// ---- verification/piopu_board.sv ----
`timescale 1ns/1ps

// Board seen by the pins: bench drivers, pull resistors, floating wires
module piopu_board
(
    // Clock
    input wire logic clk_sys,
    // Device pins
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinOeN,
    input wire logic [31:0] pullUpEn,
    input wire logic [31:0] pullDownEn,
    // Bench drivers
    input wire logic [31:0] extVal,
    input wire logic [31:0] extEn,
    output logic [31:0] pinIn
);
    logic [31:0] last_q = '0;

    // Floating wire flips each cycle so a stale value never looks valid;
    // starting low keeps an undriven pin from reading unknown forever
    always_comb
        for (int i = 0; i < 32; i++)
            if (!pinOeN[i])
                pinIn[i] = pinOut[i];
            else if (extEn[i])
                pinIn[i] = extVal[i];
            else if (pullUpEn[i])
                pinIn[i] = 1'b1;
            else if (pullDownEn[i])
                pinIn[i] = 1'b0;
            else
                pinIn[i] = ~last_q[i];

    always @(posedge clk_sys)
        last_q <= pinIn;
endmodule : piopu_board

// ---- verification/piopu_tb_top.sv ----
`timescale 1ns/1ps
`include "piopu_cfg.svh"

module piopu_tb_top;
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, strapN, errSeen;
    logic [`PIOPU_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, normOut, normOe, normIn, pinIn, pinOut, pinOeN;
    logic [31:0] pullUpEn, pullDownEn, extVal, extEn, rdData;
    int err_count, check_count;
    logic [7:0] idxTab [4];
    logic [15:0] rstTab [4];
    logic [15:0] inTab [2];

    piopu_top DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addrEnableStrapN(strapN), .normOut(normOut), .normOe(normOe),
        .normIn(normIn), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn));

    piopu_board u_board (.clk_sys(clk_sys), .pinOut(pinOut), .pinOeN(pinOeN),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extVal(extVal), .extEn(extEn),
        .pinIn(pinIn));

    always #5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Byte address is four times the register index
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'hFFFF, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_count++;
            summarize();
        end
    endtask : apb

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic doReset(input logic strapLevel);
        @(posedge clk_sys);
        reset <= 1'b1;
        strapN <= strapLevel;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        settle();
    endtask : doReset

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        strapN = 1; normOut = 32'hAAAA_AAAA; normOe = 32'h5555_5555; extVal = '0; extEn = '0;
        err_count = 0; check_count = 0;
        idxTab = '{`PIOPU_IDX_MODE_LO, `PIOPU_IDX_DIR_LO, `PIOPU_IDX_MODE_HI, `PIOPU_IDX_DIR_HI};
        rstTab = '{16'h0000, 16'hFC0F, 16'h0000, 16'hFFFF};
        inTab = '{16'h1234, 16'hEDCB};
        doReset(1'b1);
        chk("boot pull-up", 32'hFFFF_F80D, pullUpEn);
        chk("boot pull-down", 32'h0000_0402, pullDownEn);
        chk("boot oe", ~normOe & 32'h3F0, pinOeN & 32'h3F0);
        chk("boot out", normOut & 32'h3F0, pinOut & 32'h3F0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, idxTab[i], 16'h0);
            chk("reset value", {16'h0, rstTab[i]}, rdData);
        end
        apb(1'b1, 8'h71, 16'hFFFF);
        chk("unmapped write error", 32'h1, {31'h0, errSeen});
        apb(1'b0, 8'h71, 16'h0);
        chk("unmapped read error", 32'h1, {31'h0, errSeen});
        chk("unmapped data", 32'h0, rdData);
        // Level written while pins other than 4..9 are still inputs, then pins turned to outputs
        apb(1'b1, `PIOPU_IDX_MODE_LO, 16'hFFFF);
        apb(1'b1, `PIOPU_IDX_LEVEL_LO, 16'hA5C3);
        apb(1'b1, `PIOPU_IDX_DIR_LO, 16'h0000);
        settle();
        chk("low oe", 32'h0, {16'h0, pinOeN[15:0]});
        chk("low out", 32'hA5C3, {16'h0, pinOut[15:0]});
        apb(1'b0, `PIOPU_IDX_LEVEL_LO, 16'h0);
        chk("low level read", 32'hA5C3, rdData);
        // Open drain: fixed level, direction carries the value
        apb(1'b1, `PIOPU_IDX_DIR_LO, 16'h0001);
        settle();
        chk("open drain oe", 32'h1, {30'h0, pinOeN[1:0]});
        apb(1'b1, `PIOPU_IDX_MODE_HI, 16'h8001);
        apb(1'b1, `PIOPU_IDX_DIR_HI, 16'h7FFE);
        apb(1'b1, `PIOPU_IDX_LEVEL_HI, 16'h8000);
        settle();
        chk("high oe", 32'h7FFE, {16'h0, pinOeN[31:16]});
        chk("high out", 32'h8000_0000, pinOut & 32'h8001_0000);
        chk("high pull-up", 32'h7FFE, {16'h0, pullUpEn[31:16]});
        apb(1'b1, `PIOPU_IDX_MODE_HI, 16'hFFFF);
        apb(1'b1, `PIOPU_IDX_DIR_HI, 16'hFFFF);
        extEn <= 32'hFFFF_0000;
        for (int i = 0; i < 2; i++)
        begin
            extVal <= {inTab[i], 16'h0};
            settle();
            apb(1'b0, `PIOPU_IDX_LEVEL_HI, 16'h0);
            chk("high level read", {16'h0, inTab[i]}, rdData);
            chk("normal input blocked", 32'h0, {16'h0, normIn[31:16]});
        end
        apb(1'b1, `PIOPU_IDX_MODE_LO, 16'h0000);
        apb(1'b1, `PIOPU_IDX_DIR_LO, 16'hFFFF);
        settle();
        chk("low pull-down", 32'h0442, {16'h0, pullDownEn[15:0]});
        chk("low pull-up", 32'hFBBD, {16'h0, pullUpEn[15:0]});
        apb(1'b1, `PIOPU_IDX_DIR_LO, 16'h0000);
        settle();
        chk("normal oe", {16'h0, ~normOe[15:0]}, {16'h0, pinOeN[15:0]});
        chk("normal out", {16'h0, normOut[15:0]}, {16'h0, pinOut[15:0]});
        // Undriven normal pins carry the board level through to the peripherals
        extVal <= 32'h0000_A0A0;
        extEn <= 32'h0000_AAAA;
        settle();
        chk("normal input", 32'h0000_A0A0, normIn & 32'h0000_AAAA);
        extEn <= 32'h0;
        doReset(1'b0);
        chk("strap pull-up", 32'h0, pullUpEn & 32'h2400_0000);
        chk("strap oe", ~normOe & 32'h2400_0000, pinOeN & 32'h2400_0000);
        strapN <= 1'b1;
        summarize();
    end
endmodule : piopu_tb_top
